// *** hw/ssip_pkg.sv ***
// Constants, timing counts and state encoding shared by the serial position slave.
package ssip_pkg;

  // Position and frame layout.
  localparam int RES_BITS      = 16;
  localparam int SHORT_BITS    = 13;
  localparam int RING_MAX_BITS = 13;
  localparam int FRAME_BITS    = 25;
  localparam int CNT_W         = 5;
  localparam logic [CNT_W-1:0] FRAME_TOP  = 5'h18;
  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h19;
  localparam logic [CNT_W-1:0] CNT_FIRST  = 5'h01;
  localparam logic [RES_BITS-1:0] OFFSET_RST = 16'h0000;

  // Timing: the monoflop interval and the least preset hold time.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MONO_NS       = 20000;
  localparam int MONO_CYC      = (MONO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MONO_W        = 12;
  localparam logic [MONO_W-1:0] MONO_LOAD = MONO_W'(MONO_CYC);
  localparam logic [MONO_W-1:0] MONO_LAST = 12'h001;
  localparam int PRESET_MS     = 100;
  localparam int PRESET_CYC    = (PRESET_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESET_W      = 24;

  // Pin synchroniser lanes and their idle levels.
  localparam int SYNC_LANES  = 5;
  localparam int LANE_LINK   = 0;
  localparam int LANE_DIR    = 1;
  localparam int LANE_PRESET = 2;
  localparam int LANE_GRAY   = 3;
  localparam int LANE_SHORT  = 4;
  localparam logic [SYNC_LANES-1:0] PIN_RST = 5'h03;

  // Width of the falling-edge count that crosses from the link clock.
  localparam int GRAY_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_TAIL  = 3'h4
  } ssip_state_t;

endpackage

// *** hw/ssip_if.sv ***
// Carrier for the falling-edge count passed from the link clock domain to the core.
`timescale 1ns/100ps
interface ssip_if;
  import ssip_pkg::*;

  logic [GRAY_W-1:0] fall_gray;

  modport link (output fall_gray);
  modport core (input fall_gray);
endinterface

// *** hw/ssip_link.sv ***
// Link clock domain: gray-coded count of serial clock falling edges.
`timescale 1ns/100ps
module ssip_link
  import ssip_pkg::*;
(
  input wire logic link_clk,  // Serial clock from the controller
  ssip_if.link     lnk        // Falling-edge count toward the core
);

  // The link clock may stand still for long stretches, so these registers take no reset; the core
  // only looks at changes of the count, and its own copy follows the count while it is in reset.
  logic [GRAY_W-1:0] fall_bin  = '0;
  logic [GRAY_W-1:0] fall_gray = '0;
  logic [GRAY_W-1:0] next_bin;
  logic [GRAY_W-1:0] next_gray;

  always_comb begin
    next_bin  = fall_bin + 1'b1;
    next_gray = next_bin ^ (next_bin >> 1);
  end

  // Counting on the falling edge itself keeps the count valid while the clock rests high.
  always_ff @(negedge link_clk) begin
    fall_bin  <= next_bin;
    fall_gray <= next_gray;
  end

  assign lnk.fall_gray = fall_gray;

endmodule

// *** hw/ssip_top.sv ***
// Serial slave of an absolute rotary encoder: position capture, frame shifting and monoflop.
// Summary of operation
// - Clock and data rest high while idle.
// - First falling clock edge captures position word.
// - First rising edge presents the MSB.
// - Each later rising edge presents next lower bit.
// - After LSB, data held low until monoflop expires.
// - Last falling edge starts or retriggers monoflop.
// - Unbroken clocking resends the same captured word.
// - Ring-slide words are 25 bits long.
// - Pulse 26 repeats; late pulse sends fresh word.
// - Ring-slide only for words up to 13 bits.
// - Direction input acts when low.
// - Zero-set input high loads present shaft position.
// - Position resolves at most 65536 steps per turn.
// - Controller clock burst; bits returned synchronously.
// - Monoflop interval nominally 20 microseconds.
// - Output code selectable gray or binary.
// - Default direction: code falls turning clockwise.
`timescale 1ns/100ps
module ssip_top
  import ssip_pkg::*;
#(
  parameter logic [PRESET_W-1:0] PRESET_HOLD_CYC = PRESET_W'(PRESET_CYC)  // Zero-set hold in cycles
)
(
  input  wire logic                sys_clk,      // 100 MHz core clock
  input  wire logic                rst,          // Synchronous reset, active high
  input  wire logic                link_clk,     // Serial clock from the controller, rests high
  input  wire logic [RES_BITS-1:0] shaft_angle,  // Raw angle, rising clockwise, sys_clk domain
  input  wire logic                special_bit,  // Special bit sent after the position
  input  wire logic                dir_sel_n,    // Counting direction select pin, active low
  input  wire logic                preset,       // Zero-set pin, active high
  input  wire logic                code_gray,    // Configuration: 1 gray code, 0 binary
  input  wire logic                short_res,    // Configuration: 13-bit word, allows ring slide
  output logic                     ssi_data,     // Serial data line, positive sense
  output logic                     mono_active   // Monoflop interval running
);

  ssip_if lnk_if ();

  ssip_link u_link (
    .link_clk (link_clk),
    .lnk      (lnk_if.link)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three flip-flops, a change counts once the second and third agree.

  logic [SYNC_LANES-1:0] pin_raw;
  logic [SYNC_LANES-1:0] pin_s1;
  logic [SYNC_LANES-1:0] pin_s2;
  logic [SYNC_LANES-1:0] pin_s3;
  logic [SYNC_LANES-1:0] pin_q;
  logic [SYNC_LANES-1:0] next_pin_q;

  assign pin_raw = {short_res, code_gray, preset, dir_sel_n, link_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_LANES; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_s1[gi] <= PIN_RST[gi];
          pin_s2[gi] <= PIN_RST[gi];
          pin_s3[gi] <= PIN_RST[gi];
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < SYNC_LANES; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_q[i] = pin_s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_q <= PIN_RST;
    end else begin
      pin_q <= next_pin_q;
    end
  end

  logic rise_evt;
  logic dir_active;
  logic ring_ok;

  assign rise_evt   = next_pin_q[LANE_LINK] & ~pin_q[LANE_LINK];
  assign dir_active = ~pin_q[LANE_DIR];
  assign ring_ok    = pin_q[LANE_SHORT] && (SHORT_BITS <= RING_MAX_BITS);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Falling edges arrive as a gray count from the link domain.

  logic [GRAY_W-1:0] gray_s1;
  logic [GRAY_W-1:0] gray_s2;
  logic [GRAY_W-1:0] gray_prev;
  logic              fall_evt;

  // During reset the copy follows the count, so no stale edge is seen at release.
  always_ff @(posedge sys_clk) begin
    gray_s1   <= lnk_if.fall_gray;
    gray_s2   <= gray_s1;
    gray_prev <= gray_s2;
  end

  assign fall_evt = !rst && (gray_s2 != gray_prev);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Position value, direction and zero-set.

  logic [RES_BITS-1:0] offset;
  logic [RES_BITS-1:0] next_offset;
  logic [PRESET_W-1:0] preset_cnt;
  logic [PRESET_W-1:0] next_preset_cnt;
  logic                preset_take;
  logic [RES_BITS-1:0] position;

  always_comb begin
    if (dir_active) begin
      position = shaft_angle - offset;
    end else begin
      position = offset - shaft_angle;
    end
  end

  always_comb begin
    next_preset_cnt = preset_cnt;
    next_offset     = offset;
    preset_take     = 1'b0;
    if (!pin_q[LANE_PRESET]) begin
      next_preset_cnt = '0;
    end else if (preset_cnt != PRESET_HOLD_CYC) begin
      next_preset_cnt = preset_cnt + 1'b1;
      if (next_preset_cnt == PRESET_HOLD_CYC) begin
        preset_take = 1'b1;
        next_offset = shaft_angle;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preset_cnt <= '0;
      offset     <= OFFSET_RST;
    end else begin
      preset_cnt <= next_preset_cnt;
      offset     <= next_offset;
    end
  end

  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [RES_BITS-1:0] pos,
                                                        input logic                sbit,
                                                        input logic                gray,
                                                        input logic                short);
    logic [RES_BITS-1:0]   p;
    logic [FRAME_BITS-1:0] f;
    p = short ? (pos >> (RES_BITS - SHORT_BITS)) : pos;
    if (gray) begin
      p = p ^ (p >> 1);
    end
    f             = '0;
    f[RES_BITS:1] = p;
    f[0]          = sbit;
    return f;
  endfunction

  logic [FRAME_BITS-1:0] fresh_word;

  assign fresh_word = build_frame(position, special_bit, pin_q[LANE_GRAY], pin_q[LANE_SHORT]);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer and monoflop.

  ssip_state_t           state;
  ssip_state_t           next_state;
  logic [CNT_W-1:0]      bit_cnt;
  logic [CNT_W-1:0]      next_bit_cnt;
  logic [FRAME_BITS-1:0] word;
  logic [FRAME_BITS-1:0] next_word;
  logic                  next_data;
  logic [MONO_W-1:0]     mono_cnt;
  logic [MONO_W-1:0]     next_mono_cnt;
  logic                  mono_expire;

  // A falling edge in the expiry cycle wins, so a quick restart is never cut short.
  assign mono_expire = (mono_cnt == MONO_LAST) && !fall_evt;

  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_word     = word;
    next_data     = ssi_data;
    next_mono_cnt = mono_cnt;
    if (fall_evt) begin
      next_mono_cnt = MONO_LOAD;
    end else if (mono_cnt != '0) begin
      next_mono_cnt = mono_cnt - 1'b1;
    end
    case (state)
      ST_IDLE: begin
        next_data = 1'b1;
        if (fall_evt) begin
          next_state   = ST_SHIFT;
          next_word    = fresh_word;
          next_bit_cnt = '0;
        end
      end
      ST_SHIFT: begin
        if (mono_expire) begin
          next_state = ST_IDLE;
          next_data  = 1'b1;
        end else if (rise_evt) begin
          if (bit_cnt != FRAME_LAST) begin
            next_data    = word[FRAME_TOP - bit_cnt];
            next_bit_cnt = bit_cnt + 1'b1;
          end else if (ring_ok) begin
            next_data    = word[FRAME_TOP];
            next_bit_cnt = CNT_FIRST;
          end else begin
            next_state = ST_TAIL;
            next_data  = 1'b0;
          end
        end
      end
      ST_TAIL: begin
        next_data = 1'b0;
        if (mono_expire) begin
          next_state = ST_IDLE;
          next_data  = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_data  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      bit_cnt     <= '0;
      word        <= '0;
      ssi_data    <= 1'b1;
      mono_cnt    <= '0;
      mono_active <= 1'b0;
    end else begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      word        <= next_word;
      ssi_data    <= next_data;
      mono_cnt    <= next_mono_cnt;
      mono_active <= (next_mono_cnt != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_IDLE_HIGH: assert property (
    (state == ST_IDLE) |-> ssi_data)
    else $error("Data line not high while idle.");
  AST_CAPTURE: assert property (
    (state == ST_IDLE && fall_evt) |=> (state == ST_SHIFT && bit_cnt == '0 && word == $past(fresh_word)))
    else $error("Word not captured at the first falling edge.");
  AST_MSB_FIRST: assert property (
    (state == ST_SHIFT && rise_evt && !mono_expire && bit_cnt == '0) |=> (ssi_data == word[FRAME_TOP]))
    else $error("First rising edge did not present the MSB.");
  AST_NEXT_BIT: assert property (
    (state == ST_SHIFT && rise_evt && !mono_expire && bit_cnt != '0 && bit_cnt != FRAME_LAST)
    |=> (ssi_data == word[FRAME_TOP - $past(bit_cnt)] && bit_cnt == $past(bit_cnt) + 1'b1))
    else $error("Rising edge did not present the next lower bit.");
  AST_TAIL_LOW: assert property (
    (state == ST_TAIL && !mono_expire) |=> (!ssi_data && state == ST_TAIL))
    else $error("Data line left the low tail before expiry.");
  AST_MONO_START: assert property (
    fall_evt |=> (mono_cnt == MONO_LOAD) ##1 (mono_cnt == MONO_LOAD - 1'b1 || $past(fall_evt)))
    else $error("Monoflop not started by a falling edge.");
  AST_RING_REPEAT: assert property (
    (state == ST_SHIFT && rise_evt && !mono_expire && bit_cnt == FRAME_LAST && ring_ok)
    |=> (ssi_data == word[FRAME_TOP] && bit_cnt == CNT_FIRST && $stable(word)))
    else $error("Ring slide did not restart the same word.");

  AST_RING_LIMIT: assert property (
    (state == ST_SHIFT && rise_evt && !mono_expire && bit_cnt == FRAME_LAST && !ring_ok)
    |=> (state == ST_TAIL && !ssi_data))
    else $error("Long word repeated instead of holding low.");

  AST_REARM: assert property (
    (state != ST_IDLE && mono_expire) |=> (state == ST_IDLE && ssi_data && !mono_active))
    else $error("Monoflop expiry did not release the line.");

  AST_PRESET: assert property (
    preset_take |=> (offset == $past(shaft_angle)) ##1 $stable(offset))
    else $error("Zero-set did not load the shaft position.");

  COV_CAPTURE: cover property ((state == ST_IDLE && fall_evt) ##1 (state == ST_SHIFT));
  COV_RING: cover property ((state == ST_SHIFT && rise_evt && bit_cnt == FRAME_LAST && ring_ok));
  COV_TAIL_EXPIRE: cover property ((state == ST_TAIL) ##1 (state == ST_TAIL && mono_expire));
  COV_PRESET: cover property (preset_take);

endmodule

// *** tb/ssip_ctrl.sv ***
// Controller model: clock master that bursts the serial clock and gathers the returned bits.
`timescale 1ns/100ps
module ssip_ctrl (
  output logic      link_clk,  // Serial clock toward the encoder
  input  wire logic ssi_data   // Serial data from the encoder
);
  localparam real HALF_NS  = 62.5;
  localparam real PAUSE_NS = 25000.0;

  initial link_clk = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // The pause before pulse late_at outlasts the monoflop, so the encoder must re-arm.
  task automatic read_word(input int n, input int late_at, output logic [63:0] word);
    int i;
    word = '0;
    // A small offset keeps the link edges away from the core clock's sampling edges.
    #1.3;
    for (i = 0; i < 400 && ssi_data !== 1'b1; i++) #100;
    for (i = 1; i <= n; i++) begin
      if (i == late_at) #PAUSE_NS;
      link_clk = 1'b0;
      #HALF_NS;
      link_clk = 1'b1;
      #HALF_NS;
      word = {word[62:0], ssi_data};
    end
  endtask
endmodule

// *** tb/ssip_top_tb.sv ***
// Self-checking bench for the serial position slave, driven by the controller model.
`timescale 1ns/100ps
module ssip_top_tb;
  import ssip_pkg::*;
  localparam logic [PRESET_W-1:0] HOLD = 24'h000014;
  localparam int LIMIT = 60000;

  logic                sys_clk     = 1'b0;
  logic                rst         = 1'b1;
  logic [RES_BITS-1:0] shaft_angle = 16'h0000;
  logic                special_bit = 1'b0;
  logic                dir_sel_n   = 1'b1;
  logic                preset      = 1'b0;
  logic                code_gray   = 1'b0;
  logic                short_res   = 1'b0;
  logic                link_clk;
  logic                ssi_data;
  logic                mono_active;
  logic [63:0]         w;
  int                  errors      = 0;
  int                  num_checks  = 0;
  int                  cycles      = 0;

  always #5 sys_clk = ~sys_clk;

  ssip_ctrl u_ssip_ctrl (.link_clk(link_clk), .ssi_data(ssi_data));

  ssip_top #(.PRESET_HOLD_CYC(HOLD)) u_ssip_top (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .link_clk   (link_clk),
    .shaft_angle(shaft_angle),
    .special_bit(special_bit),
    .dir_sel_n  (dir_sel_n),
    .preset     (preset),
    .code_gray  (code_gray),
    .short_res  (short_res),
    .ssi_data   (ssi_data),
    .mono_active(mono_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Frame layout: leading zeros, position field, special bit last.
  function automatic logic [63:0] frame(input logic [15:0] ang, off, input logic dn, g, s, sb);
    logic [15:0] f;
    f = dn ? off - ang : ang - off;
    if (s) f = f >> 3;
    if (g) f = f ^ (f >> 1);
    return {39'h0, 8'h00, f, sb};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic setup(input logic [15:0] ang, input logic dn, g, s, sb);
    @(posedge sys_clk);
    shaft_angle <= ang;
    dir_sel_n   <= dn;
    code_gray   <= g;
    short_res   <= s;
    special_bit <= sb;
    settle(10);
  endtask

  // Returns after the line is released, so the next read never overlaps a monoflop.
  task automatic read_check(input int n, late, input logic [15:0] ang, input int at_ns);
    int cnt;
    fork
      u_ssip_ctrl.read_word(n, late, w);
      begin
        #at_ns;
        @(posedge sys_clk);
        shaft_angle <= ang;
      end
    join
    check(64'(mono_active), 64'h1);
    cnt = 0;
    while (ssi_data !== 1'b1 && cnt < 3000) begin
      @(negedge sys_clk);
      cnt++;
    end
    check(64'(cnt >= 1970 && cnt <= 2010), 64'h1);
    settle(2);
    check(64'(mono_active), 64'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    check(64'(ssi_data), 64'h1);
    check(64'(mono_active), 64'h0);
  endtask

  // Angle moves after the first fall; the captured word must not follow it.
  task automatic t_frame(input logic g, dn);
    logic [63:0] e;
    setup(16'hA5C3, dn, g, 1'b0, ~g);
    e = frame(16'hA5C3, 16'h0000, dn, g, 1'b0, ~g);
    read_check(30, 0, 16'h1234, 1000);
    check(64'(w[29:5]), e);
    check(64'(w[4:0]), 64'h0);
  endtask

  task automatic t_ring;
    logic [63:0] e;
    setup(16'h7E59, 1'b1, 1'b1, 1'b1, 1'b1);
    e = frame(16'h7E59, 16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
    // One pulse past the second word leaves the line on a leading zero, so the tail can be timed.
    read_check(51, 0, 16'h0F0F, 1000);
    check(64'(w[50:26]), e);
    check(64'(w[25:1]), e);
    check(64'(w[0]), 64'h0);
  endtask

  task automatic t_late;
    logic [63:0] a;
    logic [63:0] b;
    setup(16'h3C0F, 1'b0, 1'b0, 1'b1, 1'b0);
    a = frame(16'h3C0F, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
    b = frame(16'hC3F0, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
    read_check(50, 26, 16'hC3F0, 5000);
    check(64'(w[49:25]), a);
    check(64'(w[24:0]), b);
  endtask

  // preset held high for n core clock cycles
  task automatic pulse_preset(input int n);
    @(posedge sys_clk);
    preset <= 1'b1;
    settle(n);
    preset <= 1'b0;
    settle(10);
  endtask

  // A pulse shorter than the hold count must leave the zero point alone.
  task automatic t_preset;
    setup(16'h1111, 1'b1, 1'b0, 1'b0, 1'b1);
    pulse_preset(10);
    read_check(26, 0, 16'h1111, 100);
    check(64'(w[25:1]), frame(16'h1111, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b1));
    setup(16'h4321, 1'b1, 1'b0, 1'b0, 1'b1);
    pulse_preset(40);
    setup(16'h5000, 1'b1, 1'b0, 1'b0, 1'b1);
    read_check(26, 0, 16'h5000, 100);
    check(64'(w[25:1]), frame(16'h5000, 16'h4321, 1'b1, 1'b0, 1'b0, 1'b1));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(8);
    rst <= 1'b0;
    settle(5);
    t_idle();
    for (int g = 0; g < 2; g++)
      for (int d = 0; d < 2; d++)
        t_frame(1'(g), 1'(d));
    t_ring();
    t_late();
    t_preset();
    complete_run();
  end
endmodule
